// ---- src/gbic_pkg.sv ----
package gbic_pkg;

    // ------------------------------------------------------------
    // Host port geometry
    // ------------------------------------------------------------
    localparam int ADDR_W     = 22;
    localparam int DATA_W     = 16;
    localparam int BLOCK_LSB  = 7;
    localparam int OFS_W      = 7;

    // ------------------------------------------------------------
    // Register byte offsets inside the block
    // ------------------------------------------------------------
    localparam logic [6:0] OFS_RELOC      = 7'h00;
    localparam logic [6:0] OFS_CTRL       = 7'h02;
    localparam logic [6:0] OFS_REFRESH    = 7'h04;
    localparam logic [6:0] OFS_GEOM       = 7'h06;
    localparam logic [6:0] OFS_PRI_SCREEN = 7'h08;
    localparam logic [6:0] OFS_PRI_DRAW   = 7'h0A;
    localparam logic [6:0] OFS_PRI_HOST   = 7'h0C;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int RELOC_SPACE_BIT = 0;
    localparam int CTRL_GUARD1_BIT = 0;
    localparam int CTRL_GUARD2_BIT = 1;
    localparam int CTRL_DRAW_IRQ   = 2;
    localparam int CTRL_SCREEN_IRQ = 3;
    localparam int CTRL_WIDTH_BIT  = 4;
    localparam int CTRL_WAIT_BIT   = 5;
    localparam int CTRL_VIDEO_BIT  = 6;
    localparam int GEOM_DEPTH_LSB  = 0;
    localparam int GEOM_CFG_LSB    = 3;
    localparam int GEOM_ROWS_LSB   = 5;
    localparam int PRI_RETAIN_LSB  = 0;
    localparam int PRI_ACQ_LSB     = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_RELOC   = 16'h0000;
    localparam logic [15:0] RST_CTRL    = 16'h0000;
    localparam logic [15:0] RST_REFRESH = 16'h003F;
    localparam logic [15:0] RST_GEOM    = 16'h0000;
    localparam logic [15:0] RST_PRI     = 16'h0000;

    // ------------------------------------------------------------
    // Refresh timing and encodings
    // ------------------------------------------------------------
    localparam logic [5:0]  REFRESH_OFF   = 6'h3F;
    localparam logic [10:0] REFRESH_UNIT  = 11'h010;
    localparam logic [1:0]  ROWS_ONE      = 2'h0;
    localparam logic [1:0]  CFG_FPM_ILV   = 2'h3;
    localparam logic [2:0]  DEPTH_256K    = 3'h5;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic              rd;
        logic              wr;
        logic              mem_space;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } gbic_host_req_t;

    typedef struct packed {
        logic       refresh;
        logic       screen;
        logic       host;
        logic       drawing;
    } gbic_req_t;

    typedef struct packed {
        logic       video_cycle;
        logic       wait_count;
        logic       word_width;
        logic [1:0] rows;
        logic [1:0] mem_cfg;
        logic [2:0] depth;
    } gbic_cfg_t;

    typedef enum logic [4:0] {
        OWN_IDLE    = 5'b00001,
        OWN_REFRESH = 5'b00010,
        OWN_SCREEN  = 5'b00100,
        OWN_HOST    = 5'b01000,
        OWN_DRAW    = 5'b10000
    } gbic_owner_t;

endpackage

// ---- src/gbic_refresh_timer.sv ----
`timescale 1ns/1ps
module gbic_refresh_timer (
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    input  wire logic [5:0] scalar_i,
    output logic            due_o
);
    logic [10:0] cnt_q;
    logic [10:0] cnt_d;
    logic [10:0] limit;
    logic        due_d;

    // ------------------------------------------------------------
    // Period counter
    // ------------------------------------------------------------
    // Period is (scalar + 1) * 16 clocks; all ones stops refresh
    always_comb begin
        limit = 11'((12'(scalar_i) + 12'h001) * 12'(gbic_pkg::REFRESH_UNIT))
                - 11'h001;
        cnt_d = cnt_q + 11'h001;
        due_d = 1'b0;
        if (scalar_i == gbic_pkg::REFRESH_OFF) begin
            cnt_d = 11'h000;
        end else if (cnt_q >= limit) begin
            cnt_d = 11'h000;
            due_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cnt_q <= 11'h000;
            due_o <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            due_o <= due_d;
        end
    end

    a_refresh_stopped: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        $past(scalar_i) == gbic_pkg::REFRESH_OFF |-> !due_o)
        else $error("refresh request while scalar is all ones");
endmodule

// ---- src/gbic_config.sv ----
`timescale 1ns/1ps
module gbic_config (
    input  wire logic                    core_clk_i,
    input  wire logic                    rst_i,
    input  wire gbic_pkg::gbic_host_req_t host_req_i,
    output logic                         host_ack_o,
    output logic [15:0]                  host_rdata_o,
    input  wire logic                    draw_irq_i,
    input  wire logic                    screen_irq_i,
    input  wire gbic_pkg::gbic_req_t     bus_req_i,
    input  wire logic                    cycle_done_i,
    output gbic_pkg::gbic_req_t          bus_grant_o,
    output logic                         refresh_pending_o,
    output gbic_pkg::gbic_cfg_t          cfg_o,
    output logic                         rows_one_o,
    output logic                         fpm_interleaved_o,
    output logic                         depth_256k_o
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [15:0] reloc_q, reloc_d;
    logic [15:0] ctrl_q, ctrl_d;
    logic [15:0] refresh_q, refresh_d;
    logic [15:0] geom_q, geom_d;
    logic [15:0] pri_scr_q, pri_scr_d;
    logic [15:0] pri_drw_q, pri_drw_d;
    logic [15:0] pri_hst_q, pri_hst_d;
    logic        busy_q, busy_d;
    logic        wait_q, wait_d;
    logic        ack_d;
    logic [15:0] rdata_d;
    logic        hit;
    logic        word_mode;
    logic [6:0]  ofs;
    logic [15:0] rd_word;
    logic [15:0] wr_word;

    assign word_mode = ctrl_q[gbic_pkg::CTRL_WIDTH_BIT];

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Uses the stored relocation and width, so a write to them only
    // steers later accesses, never the one in flight.
    always_comb begin
        hit = (host_req_i.rd || host_req_i.wr) && !busy_q
              && host_req_i.addr[gbic_pkg::ADDR_W-1:gbic_pkg::BLOCK_LSB]
                 == reloc_q[15:1]
              && host_req_i.mem_space
                 == reloc_q[gbic_pkg::RELOC_SPACE_BIT];
        ofs = {host_req_i.addr[6:1], 1'b0};
    end

    // Word view of the addressed register; flags come live from engines
    always_comb begin
        case (ofs)
            gbic_pkg::OFS_RELOC:      rd_word = reloc_q;
            gbic_pkg::OFS_CTRL: begin
                rd_word = ctrl_q;
                rd_word[gbic_pkg::CTRL_DRAW_IRQ]   = draw_irq_i;
                rd_word[gbic_pkg::CTRL_SCREEN_IRQ] = screen_irq_i;
            end
            gbic_pkg::OFS_REFRESH:    rd_word = refresh_q;
            gbic_pkg::OFS_GEOM:       rd_word = geom_q;
            gbic_pkg::OFS_PRI_SCREEN: rd_word = pri_scr_q;
            gbic_pkg::OFS_PRI_DRAW:   rd_word = pri_drw_q;
            gbic_pkg::OFS_PRI_HOST:   rd_word = pri_hst_q;
            default:                  rd_word = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------
    // Register writes and access timing
    // ------------------------------------------------------------
    always_comb begin
        reloc_d   = reloc_q;
        ctrl_d    = ctrl_q;
        refresh_d = refresh_q;
        geom_d    = geom_q;
        pri_scr_d = pri_scr_q;
        pri_drw_d = pri_drw_q;
        pri_hst_d = pri_hst_q;
        busy_d    = busy_q;
        wait_d    = wait_q;
        ack_d     = 1'b0;
        rdata_d   = host_rdata_o;
        wr_word   = rd_word;
        // Byte mode: one lane on data[7:0], address bit 0 picks the byte
        if (word_mode) begin
            wr_word = host_req_i.wdata;
        end else if (host_req_i.addr[0]) begin
            wr_word[15:8] = host_req_i.wdata[7:0];
        end else begin
            wr_word[7:0] = host_req_i.wdata[7:0];
        end
        if (hit && host_req_i.wr) begin
            case (ofs)
                gbic_pkg::OFS_RELOC:      reloc_d   = wr_word;
                gbic_pkg::OFS_CTRL:       ctrl_d    = wr_word;
                gbic_pkg::OFS_REFRESH:    refresh_d = {10'h000, wr_word[5:0]};
                gbic_pkg::OFS_GEOM:       geom_d    = {9'h000, wr_word[6:0]};
                gbic_pkg::OFS_PRI_SCREEN: pri_scr_d = {10'h000, wr_word[5:0]};
                gbic_pkg::OFS_PRI_DRAW:   pri_drw_d = {10'h000, wr_word[5:0]};
                gbic_pkg::OFS_PRI_HOST:   pri_hst_d = {10'h000, wr_word[5:0]};
                default:                  reloc_d   = reloc_q;
            endcase
        end
        // Flag bits are not storage
        ctrl_d[gbic_pkg::CTRL_DRAW_IRQ]   = 1'b0;
        ctrl_d[gbic_pkg::CTRL_SCREEN_IRQ] = 1'b0;
        if (hit) begin
            rdata_d = 16'h0000;
            if (host_req_i.rd) begin
                if (word_mode) begin
                    rdata_d = rd_word;
                end else begin
                    rdata_d = {8'h00, host_req_i.addr[0] ? rd_word[15:8]
                                                        : rd_word[7:0]};
                end
            end
            // One wait state added when the wait count bit is set
            if (ctrl_q[gbic_pkg::CTRL_WAIT_BIT]) begin
                busy_d = 1'b1;
                wait_d = 1'b1;
            end else begin
                ack_d = 1'b1;
            end
        end else if (busy_q) begin
            busy_d = 1'b0;
            wait_d = 1'b0;
            ack_d  = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            reloc_q      <= gbic_pkg::RST_RELOC;
            ctrl_q       <= gbic_pkg::RST_CTRL;
            refresh_q    <= gbic_pkg::RST_REFRESH;
            geom_q       <= gbic_pkg::RST_GEOM;
            pri_scr_q    <= gbic_pkg::RST_PRI;
            pri_drw_q    <= gbic_pkg::RST_PRI;
            pri_hst_q    <= gbic_pkg::RST_PRI;
            busy_q       <= 1'b0;
            wait_q       <= 1'b0;
            host_ack_o   <= 1'b0;
            host_rdata_o <= 16'h0000;
        end else begin
            reloc_q      <= reloc_d;
            ctrl_q       <= ctrl_d;
            refresh_q    <= refresh_d;
            geom_q       <= geom_d;
            pri_scr_q    <= pri_scr_d;
            pri_drw_q    <= pri_drw_d;
            pri_hst_q    <= pri_hst_d;
            busy_q       <= busy_d;
            wait_q       <= wait_d;
            host_ack_o   <= ack_d;
            host_rdata_o <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Configuration outputs
    // ------------------------------------------------------------
    always_comb begin
        cfg_o.video_cycle = ctrl_q[gbic_pkg::CTRL_VIDEO_BIT];
        cfg_o.wait_count  = ctrl_q[gbic_pkg::CTRL_WAIT_BIT];
        cfg_o.word_width  = word_mode;
        cfg_o.rows        = geom_q[gbic_pkg::GEOM_ROWS_LSB +: 2];
        cfg_o.mem_cfg     = geom_q[gbic_pkg::GEOM_CFG_LSB +: 2];
        cfg_o.depth       = geom_q[gbic_pkg::GEOM_DEPTH_LSB +: 3];
        rows_one_o        = cfg_o.rows == gbic_pkg::ROWS_ONE;
        fpm_interleaved_o = cfg_o.mem_cfg == gbic_pkg::CFG_FPM_ILV;
        depth_256k_o      = cfg_o.depth == gbic_pkg::DEPTH_256K;
    end

    // ------------------------------------------------------------
    // Refresh request
    // ------------------------------------------------------------
    logic refresh_due;
    logic ref_pend_q, ref_pend_d;
    gbic_pkg::gbic_owner_t owner_q, owner_d;

    gbic_refresh_timer u_refresh (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .scalar_i   (refresh_q[5:0]),
        .due_o      (refresh_due)
    );

    // A new due tick in the serving cycle keeps the request alive
    always_comb begin
        ref_pend_d = (ref_pend_q && !(owner_q == gbic_pkg::OWN_REFRESH
                     && cycle_done_i)) || refresh_due || bus_req_i.refresh;
    end

    // ------------------------------------------------------------
    // Bus arbitration
    // ------------------------------------------------------------
    // Priority fields: acquire in [5:3], retain in [2:0]
    function automatic logic [2:0] acq_of(input gbic_pkg::gbic_owner_t o,
                                          input logic [15:0] s,
                                          input logic [15:0] d,
                                          input logic [15:0] h);
        case (o)
            gbic_pkg::OWN_SCREEN: acq_of = s[gbic_pkg::PRI_ACQ_LSB +: 3];
            gbic_pkg::OWN_HOST:   acq_of = h[gbic_pkg::PRI_ACQ_LSB +: 3];
            gbic_pkg::OWN_DRAW:   acq_of = d[gbic_pkg::PRI_ACQ_LSB +: 3];
            default:              acq_of = 3'h0;
        endcase
    endfunction

    logic [2:0] retain;
    logic [2:0] best_acq;
    logic       owner_req;
    gbic_pkg::gbic_owner_t best;

    // Best waiting requester other than the owner; ties go screen first
    always_comb begin
        best     = gbic_pkg::OWN_IDLE;
        best_acq = 3'h0;
        if (bus_req_i.drawing && owner_q != gbic_pkg::OWN_DRAW) begin
            best     = gbic_pkg::OWN_DRAW;
            best_acq = pri_drw_q[gbic_pkg::PRI_ACQ_LSB +: 3];
        end
        if (bus_req_i.host && owner_q != gbic_pkg::OWN_HOST
            && (best == gbic_pkg::OWN_IDLE
                || pri_hst_q[gbic_pkg::PRI_ACQ_LSB +: 3] >= best_acq)) begin
            best     = gbic_pkg::OWN_HOST;
            best_acq = pri_hst_q[gbic_pkg::PRI_ACQ_LSB +: 3];
        end
        if (bus_req_i.screen && owner_q != gbic_pkg::OWN_SCREEN
            && (best == gbic_pkg::OWN_IDLE
                || pri_scr_q[gbic_pkg::PRI_ACQ_LSB +: 3] >= best_acq)) begin
            best     = gbic_pkg::OWN_SCREEN;
            best_acq = pri_scr_q[gbic_pkg::PRI_ACQ_LSB +: 3];
        end
        case (owner_q)
            gbic_pkg::OWN_SCREEN: begin
                retain    = pri_scr_q[gbic_pkg::PRI_RETAIN_LSB +: 3];
                owner_req = bus_req_i.screen;
            end
            gbic_pkg::OWN_HOST: begin
                retain    = pri_hst_q[gbic_pkg::PRI_RETAIN_LSB +: 3];
                owner_req = bus_req_i.host;
            end
            gbic_pkg::OWN_DRAW: begin
                retain    = pri_drw_q[gbic_pkg::PRI_RETAIN_LSB +: 3];
                owner_req = bus_req_i.drawing;
            end
            default: begin
                retain    = 3'h7;
                owner_req = 1'b0;
            end
        endcase
    end

    // Live register values steer every decision, so reprogramming acts
    // on the next choice with no reset
    always_comb begin
        owner_d = owner_q;
        case (owner_q)
            gbic_pkg::OWN_IDLE: begin
                if (ref_pend_q) begin
                    owner_d = gbic_pkg::OWN_REFRESH;
                end else begin
                    owner_d = best;
                end
            end
            gbic_pkg::OWN_REFRESH: begin
                if (cycle_done_i) begin
                    owner_d = best;
                end
            end
            gbic_pkg::OWN_SCREEN, gbic_pkg::OWN_HOST, gbic_pkg::OWN_DRAW:
            begin
                if (cycle_done_i) begin
                    if (ref_pend_q) begin
                        owner_d = gbic_pkg::OWN_REFRESH;
                    end else if (!owner_req) begin
                        owner_d = best;
                    end else if (best != gbic_pkg::OWN_IDLE
                                 && best_acq > retain) begin
                        owner_d = best;
                    end
                end
            end
            default: owner_d = gbic_pkg::OWN_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            owner_q    <= gbic_pkg::OWN_IDLE;
            ref_pend_q <= 1'b0;
        end else begin
            owner_q    <= owner_d;
            ref_pend_q <= ref_pend_d;
        end
    end

    always_comb begin
        bus_grant_o.refresh = owner_q == gbic_pkg::OWN_REFRESH;
        bus_grant_o.screen  = owner_q == gbic_pkg::OWN_SCREEN;
        bus_grant_o.host    = owner_q == gbic_pkg::OWN_HOST;
        bus_grant_o.drawing = owner_q == gbic_pkg::OWN_DRAW;
        refresh_pending_o   = ref_pend_q;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_refresh_takes_bus: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        ref_pend_q && owner_q != gbic_pkg::OWN_REFRESH
        && (cycle_done_i || owner_q == gbic_pkg::OWN_IDLE)
        |=> owner_q == gbic_pkg::OWN_REFRESH)
        else $error("pending refresh did not take the bus");

    a_handover_cycle_end: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        owner_q != gbic_pkg::OWN_IDLE && !cycle_done_i
        |=> $stable(owner_q))
        else $error("bus owner changed in mid cycle");

    a_owner_keeps_bus: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        owner_q == gbic_pkg::OWN_HOST && bus_req_i.host && !ref_pend_q
        && cycle_done_i
        && pri_hst_q[2:0] >= pri_scr_q[5:3]
        && pri_hst_q[2:0] >= pri_drw_q[5:3]
        |=> owner_q == gbic_pkg::OWN_HOST)
        else $error("host lost bus despite higher retain level");

    a_ack_no_wait: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        hit && !ctrl_q[gbic_pkg::CTRL_WAIT_BIT] |=> host_ack_o)
        else $error("access without wait state not acked next cycle");

    a_ack_one_wait: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        hit && ctrl_q[gbic_pkg::CTRL_WAIT_BIT]
        |=> wait_q && !host_ack_o ##1 host_ack_o)
        else $error("wait state access not acked after one wait");

    a_space_mismatch: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        !busy_q && host_req_i.mem_space != reloc_q[0] |=> !host_ack_o)
        else $error("block answered in the wrong address space");

    a_byte_read_lane: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        hit && host_req_i.rd && !word_mode
        |=> host_ack_o && host_rdata_o[15:8] == 8'h00)
        else $error("byte mode read drove the upper lane");

    a_width_next_access: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        hit && host_req_i.wr && ofs == gbic_pkg::OFS_CTRL
        && !host_req_i.addr[0]
        |=> word_mode == $past(host_req_i.wdata[gbic_pkg::CTRL_WIDTH_BIT]))
        else $error("width switch not stored for next access");
endmodule

// ---- test/gbic_host_model.sv ----
`timescale 1ns/1ps
// Host CPU that reaches the register block over the slave port
module gbic_host_model (
    input  wire logic                   core_clk_i,
    input  wire logic                   ack_i,
    input  wire logic [15:0]            rdata_i,
    output gbic_pkg::gbic_host_req_t    req_o
);
    logic [21:0] base = 22'h000000; // Kept on a 128-byte boundary
    logic        mem  = 1'b0;
    logic        word = 1'b0;       // Byte lanes until word width
    initial req_o = '0;
    // ------------------------------------------------------------
    // One strobe, then wait a bounded time for the acknowledge
    // ------------------------------------------------------------
    task automatic acc(input logic w, input logic [6:0] o,
                       input logic [15:0] d, output logic [15:0] q,
                       output int lat);
        @(posedge core_clk_i);
        req_o <= '{rd: !w, wr: w, mem_space: mem,
                   addr: base | {15'h0000, o}, wdata: d};
        @(posedge core_clk_i);
        req_o.rd    <= 1'b0;
        req_o.wr    <= 1'b0;
        req_o.wdata <= ~d;          // Released bus shows no stale data
        lat = 0;
        q   = 16'h0000;
        // Answer taken at the edge where the acknowledge is seen high;
        // an unknown acknowledge counts as an answer so it cannot hide
        for (int n = 1; n <= 4 && lat == 0; n++) begin
            @(posedge core_clk_i);
            if (ack_i !== 1'b0) begin
                lat = n;
                q   = rdata_i;
            end
        end
    endtask
    // Whole register, split into bytes while in byte mode
    task automatic reg16(input logic w, input logic [6:0] o,
                         input logic [15:0] d, output logic [15:0] q,
                         output int lat);
        logic [15:0] b;
        if (word) begin
            acc(w, o, d, q, lat);
        end else begin
            acc(w, o, {8'h00, d[7:0]}, b, lat);
            acc(w, o | 7'h01, {8'h00, d[15:8]}, q, lat);
            q = {q[7:0], b[7:0]};
        end
    endtask
endmodule

// ---- test/test_graphics_bus_interface_config.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module test_graphics_bus_interface_config;
    logic                     core_clk_i   = 1'b0;
    logic                     rst_i        = 1'b1;
    logic                     draw_irq_i   = 1'b0;
    logic                     screen_irq_i = 1'b0;
    logic                     cycle_done_i = 1'b0;
    gbic_pkg::gbic_req_t      bus_req_i    = '0;
    gbic_pkg::gbic_host_req_t host_req;
    gbic_pkg::gbic_req_t      grant;
    gbic_pkg::gbic_cfg_t      cfg;
    logic                     ack, pend, one, fpm, d256;
    logic [15:0]              rdata, q, v;
    int                       errors = 0, cmp_count = 0, lat, cyc = 0;
    always #5 core_clk_i = ~core_clk_i;
    gbic_config gbic_config_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .host_req_i(host_req), .host_ack_o(ack), .host_rdata_o(rdata),
        .draw_irq_i(draw_irq_i), .screen_irq_i(screen_irq_i),
        .bus_req_i(bus_req_i), .cycle_done_i(cycle_done_i),
        .bus_grant_o(grant), .refresh_pending_o(pend), .cfg_o(cfg),
        .rows_one_o(one), .fpm_interleaved_o(fpm), .depth_256k_o(d256));
    gbic_host_model h (.core_clk_i(core_clk_i), .ack_i(ack),
        .rdata_i(rdata), .req_o(host_req));
    // ------------------------------------------------------------
    // Verdict and hang guard
    // ------------------------------------------------------------
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            test_done();
        end
    end
    // Let n edges pass; checks then see values held before the edge
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    // Decodes that a geometry word should raise, from the field map
    function automatic logic [2:0] exp_geom(input logic [15:0] w);
        return {w[6:5] == 2'h0, w[4:3] == 2'h3, w[2:0] == 3'h5};
    endfunction
    // One memory cycle ends
    task automatic done_pulse;
        @(posedge core_clk_i);
        cycle_done_i <= 1'b1;
        @(posedge core_clk_i);
        cycle_done_i <= 1'b0;
    endtask
    initial begin
        q = $urandom(77);
        repeat (8) @(posedge core_clk_i);
        rst_i <= 1'b0;
        h.reg16(0, gbic_pkg::OFS_REFRESH, 16'h0000, q, lat);
        `CHK(q, gbic_pkg::RST_REFRESH)
        h.mem = 1'b1;
        h.acc(0, gbic_pkg::OFS_CTRL, 16'h0000, q, lat);
        `CHK(lat, 0)
        h.mem = 1'b0;
        // Relocate high byte first so the second byte still hits
        h.acc(1, 7'h01, 16'h0001, q, lat);
        h.base = 22'h004000;
        h.acc(1, 7'h00, 16'h0010, q, lat);
        `CHK(lat, 1)
        h.base = 22'h004400;
        h.reg16(0, gbic_pkg::OFS_RELOC, 16'h0000, q, lat);
        `CHK(q, 16'h0110)
        $display("relocation test done");
        // Low control byte alone: a high byte after it would already
        // land in word mode and clear what the low byte set
        h.acc(1, gbic_pkg::OFS_CTRL, 16'h0030, q, lat);
        `CHK(lat, 1)
        h.word = 1'b1;
        draw_irq_i <= 1'b1;
        h.reg16(0, gbic_pkg::OFS_CTRL, 16'h0000, q, lat);
        `CHK(q, 16'h0034)
        `CHK(lat, 2)
        `CHK({cfg.word_width, cfg.video_cycle}, 2'h2)
        `CHK(cfg.wait_count, 1'b1)
        h.reg16(1, gbic_pkg::OFS_CTRL, 16'h0050, q, lat);
        draw_irq_i   <= 1'b0;
        screen_irq_i <= 1'b1;
        h.reg16(0, gbic_pkg::OFS_CTRL, 16'h0000, q, lat);
        `CHK(q, 16'h0058)
        `CHK(lat, 1)
        `CHK(cfg.video_cycle, 1'b1)
        $display("control test done");
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 16'h001D : 16'($urandom);
            h.reg16(1, gbic_pkg::OFS_GEOM, v, q, lat);
            h.reg16(0, gbic_pkg::OFS_GEOM, 16'h0000, q, lat);
            `CHK(q, v & 16'h007F)
            `CHK({cfg.rows, cfg.mem_cfg, cfg.depth}, v[6:0])
            `CHK({one, fpm, d256}, exp_geom(v))
            h.reg16(1, 7'(8 + 2 * (i % 3)), v, q, lat);
            h.reg16(0, 7'(8 + 2 * (i % 3)), 16'h0000, q, lat);
            `CHK(q, v & 16'h003F)
        end
        $display("geometry and priority test done");
        h.reg16(1, gbic_pkg::OFS_PRI_SCREEN, 16'h003F, q, lat);
        h.reg16(1, gbic_pkg::OFS_PRI_DRAW, 16'h0009, q, lat);
        h.reg16(1, gbic_pkg::OFS_PRI_HOST, 16'h0028, q, lat);
        bus_req_i <= 4'h2;
        wt(3);
        `CHK(grant, 4'h2)
        bus_req_i <= 4'h7;
        wt(3);
        `CHK(grant, 4'h2)
        done_pulse();
        wt(2);
        `CHK(grant, 4'h4)
        // Scalar 0: first refresh due 16 clocks after the write edge
        h.reg16(1, gbic_pkg::OFS_REFRESH, 16'h0000, q, lat);
        wt(14);
        `CHK(pend, 1'b0)
        wt(4);
        `CHK(pend, 1'b1)
        done_pulse();
        wt(2);
        `CHK(grant, 4'h8)
        h.reg16(1, gbic_pkg::OFS_REFRESH, 16'h003F, q, lat);
        done_pulse();
        wt(60);
        `CHK(pend, 1'b0)
        bus_req_i <= 4'h2;
        done_pulse();
        wt(2);
        `CHK(grant, 4'h2)
        // Host retain raised while it owns the bus; screen may not take it
        h.reg16(1, gbic_pkg::OFS_PRI_HOST, 16'h0007, q, lat);
        bus_req_i <= 4'h7;
        done_pulse();
        wt(2);
        `CHK(grant, 4'h2)
        $display("arbiter test done");
        test_done();
    end
endmodule
